//--- hw/rcr_regs.svh
// Offsets, field positions, masks and codes of the regulator control bank.
// Assumes an 8-bit register address space on one functional page.
`ifndef RCR_REGS_SVH
`define RCR_REGS_SVH

`define RCR_NUM_REGS 8
`define RCR_ZERO_BYTE 8'h00

// Register addresses on the functional page
`define RCR_ADDR_BUCK3_MODE 8'h20
`define RCR_ADDR_BUCK3_CONF 8'h21
`define RCR_ADDR_BACKUP 8'h22
`define RCR_ADDR_LDO1 8'h23
`define RCR_ADDR_LDO2 8'h24
`define RCR_ADDR_SD_LDO 8'h25
`define RCR_ADDR_LDO_3V3 8'h26
`define RCR_ADDR_LDO3 8'h27

// Storage slot of each register
`define RCR_IDX_BUCK3_MODE 3'h0
`define RCR_IDX_BUCK3_CONF 3'h1
`define RCR_IDX_BACKUP 3'h2
`define RCR_IDX_LDO1 3'h3
`define RCR_IDX_LDO2 3'h4
`define RCR_IDX_SD_LDO 3'h5
`define RCR_IDX_LDO_3V3 3'h6
`define RCR_IDX_LDO3 3'h7

// Implemented bits of each register
`define RCR_MASK_BUCK3_MODE 8'h0F
`define RCR_MASK_BUCK3_CONF 8'h3D
`define RCR_MASK_BACKUP 8'h07
`define RCR_MASK_LDO4B 8'h1F
`define RCR_MASK_LDO2B 8'h13

// Field positions
`define RCR_MODE_HI 3
`define RCR_PHASE_HI 5
`define RCR_PHASE_LO 4
`define RCR_FREQ_HI 3
`define RCR_FREQ_LO 2
`define RCR_ILIM_BIT 0
`define RCR_BACKUP_HI 2
`define RCR_EN_BIT 4
`define RCR_VOLT4_HI 3
`define RCR_VOLT2_HI 1

`endif

//--- hw/rcr_pkg.sv
// Types shared by the regulator control bank and its storage.
// Assumes rcr_regs.svh for all numeric constants.
package rcr_pkg;
  typedef logic [7:0] rcr_reg_t;
  typedef logic [2:0] rcr_idx_t;
  typedef logic [7:0][7:0] rcr_bank_t;
  typedef struct packed {
    logic hit;
    rcr_idx_t idx;
  } rcr_dec_t;
endpackage : rcr_pkg

//--- hw/rcr_bank_if.sv
// Carrier between the bank control logic and its register storage.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface rcr_bank_if;
  import rcr_pkg::*;
  logic ld;
  rcr_bank_t ld_vals;
  logic wr_en;
  rcr_idx_t wr_idx;
  rcr_reg_t wr_data;
  logic rd_en;
  logic rd_hit;
  rcr_idx_t rd_idx;
  rcr_bank_t regs;
  rcr_reg_t rd_data;
  modport ctrl (output ld, ld_vals, wr_en, wr_idx, wr_data, rd_en, rd_hit,
    rd_idx, input regs, rd_data);
  modport store (input ld, ld_vals, wr_en, wr_idx, wr_data, rd_en, rd_hit,
    rd_idx, output regs, rd_data);
endinterface : rcr_bank_if

//--- hw/rcr_bank_mem.sv
// Eight-byte register storage with a registered read port.
// Assumes the controller masks data and raises ld during reset.
`timescale 1ns/1ps
`include "rcr_regs.svh"
module rcr_bank_mem
  import rcr_pkg::*;
(
  input wire logic i_clk_sys, // System clock
  rcr_bank_if.store bank // Storage side of the bank carrier
);

  // Contents: reload wins over any write, so reset always lands cleanly
  always_ff @(posedge i_clk_sys)
  begin
    if (bank.ld)
      bank.regs <= bank.ld_vals;
    else if (bank.wr_en)
      bank.regs[bank.wr_idx] <= bank.wr_data;
  end

  // Read sees the value before a same-cycle write
  always_ff @(posedge i_clk_sys)
  begin
    if (bank.ld)
      bank.rd_data <= `RCR_ZERO_BYTE;
    else if (bank.rd_en && bank.rd_hit)
      bank.rd_data <= bank.regs[bank.rd_idx];
    else if (bank.rd_en)
      bank.rd_data <= `RCR_ZERO_BYTE; // Reserved address
  end

endmodule : rcr_bank_mem

//--- hw/rcr_top.sv
// Regulator control bank: buck3 mode and setup, backup supply, LDO controls.
// Assumes the serial control engine presents decoded byte accesses
// synchronous to i_clk_sys, and the analog side samples the field outputs.
`timescale 1ns/1ps
`include "rcr_regs.svh"
module rcr_top
  import rcr_pkg::*;
(
  input wire logic i_clk_sys, // System clock, 125 MHz
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic [7:0] i_reg_addr, // Register address
  input wire logic i_reg_wr, // Write strobe
  input wire logic [7:0] i_reg_wdata, // Write data
  input wire logic i_reg_rd, // Read strobe
  output logic [7:0] o_reg_rdata, // Read data, one cycle after strobe
  output logic o_reg_rvalid, // Read data valid pulse
  input wire logic [7:0] i_otp_buck3_conf, // Programmed buck3 setup
  input wire logic [7:0] i_seq_buck3_mode, // Start-up buck3 mode
  input wire logic [7:0] i_seq_backup, // Start-up backup supply
  input wire logic [7:0] i_seq_ldo1, // Start-up LDO1 control
  input wire logic [7:0] i_seq_ldo2, // Start-up LDO2 control
  input wire logic [7:0] i_seq_sd_ldo, // Start-up SD card LDO
  input wire logic [7:0] i_seq_ldo_3v3, // Start-up 3.3 V LDO
  input wire logic [7:0] i_seq_ldo3, // Start-up LDO3 control
  output logic [3:0] o_buck3_mode_select, // Buck3 switching mode
  output logic [1:0] o_buck3_phase_select, // Buck3 phase clock
  output logic [1:0] o_buck3_frequency_select, // Buck3 frequency
  output logic o_buck3_current_limit_select, // 0: 3.0 A, 1: 2.25 A
  output logic [2:0] o_backup_supply_voltage_code, // Backup voltage
  output logic o_ldo1_enable, // LDO1 on
  output logic [3:0] o_ldo1_voltage_code, // LDO1 voltage
  output logic o_ldo2_enable, // LDO2 on
  output logic [3:0] o_ldo2_voltage_code, // LDO2 voltage
  output logic o_sd_card_ldo_enable, // SD card LDO on
  output logic [1:0] o_sd_card_ldo_voltage_code, // SD card LDO voltage
  output logic o_ldo_3v3_enable, // 3.3 V LDO on
  output logic [1:0] o_ldo_3v3_voltage_code, // 3.3 V LDO voltage
  output logic o_ldo3_enable, // LDO3 on
  output logic [3:0] o_ldo3_voltage_code // LDO3 voltage
);

  rcr_bank_if bank ();

  // Address to slot; anything else on the page is reserved
  // byte address decode
  function automatic rcr_dec_t rcr_decode(input logic [7:0] addr);
    rcr_dec_t d;
    d.hit = 1'b1;
    d.idx = `RCR_IDX_BUCK3_MODE;
    case (addr)
      `RCR_ADDR_BUCK3_MODE: d.idx = `RCR_IDX_BUCK3_MODE;
      `RCR_ADDR_BUCK3_CONF: d.idx = `RCR_IDX_BUCK3_CONF;
      `RCR_ADDR_BACKUP: d.idx = `RCR_IDX_BACKUP;
      `RCR_ADDR_LDO1: d.idx = `RCR_IDX_LDO1;
      `RCR_ADDR_LDO2: d.idx = `RCR_IDX_LDO2;
      `RCR_ADDR_SD_LDO: d.idx = `RCR_IDX_SD_LDO;
      `RCR_ADDR_LDO_3V3: d.idx = `RCR_IDX_LDO_3V3;
      `RCR_ADDR_LDO3: d.idx = `RCR_IDX_LDO3;
      default: d.hit = 1'b0;
    endcase
    return d;
  endfunction : rcr_decode

  // Implemented bits per slot; used for writes and for reset loads
  function automatic rcr_reg_t rcr_field_mask(input rcr_idx_t idx);
    rcr_reg_t m;
    case (idx)
      `RCR_IDX_BUCK3_MODE: m = `RCR_MASK_BUCK3_MODE;
      `RCR_IDX_BUCK3_CONF: m = `RCR_MASK_BUCK3_CONF;
      `RCR_IDX_BACKUP: m = `RCR_MASK_BACKUP;
      `RCR_IDX_SD_LDO: m = `RCR_MASK_LDO2B;
      `RCR_IDX_LDO_3V3: m = `RCR_MASK_LDO2B;
      default: m = `RCR_MASK_LDO4B;
    endcase
    return m;
  endfunction : rcr_field_mask

  // Decoded access
  rcr_dec_t wr_dec;
  rcr_dec_t rd_dec;
  assign wr_dec = rcr_decode(i_reg_addr);
  assign rd_dec = rcr_decode(i_reg_addr);

  // Raw reset sources, one per slot
  rcr_bank_t seed;
  assign seed[`RCR_IDX_BUCK3_CONF] = i_otp_buck3_conf;
  assign seed[`RCR_IDX_BUCK3_MODE] = i_seq_buck3_mode;
  assign seed[`RCR_IDX_BACKUP] = i_seq_backup;
  assign seed[`RCR_IDX_LDO1] = i_seq_ldo1;
  assign seed[`RCR_IDX_LDO2] = i_seq_ldo2;
  assign seed[`RCR_IDX_SD_LDO] = i_seq_sd_ldo;
  assign seed[`RCR_IDX_LDO_3V3] = i_seq_ldo_3v3;
  assign seed[`RCR_IDX_LDO3] = i_seq_ldo3;

  // Masking the load keeps unused bits zero even with odd sources
  rcr_bank_t load_vals;
  genvar gi;
  generate
    for (gi = 0; gi < `RCR_NUM_REGS; gi++)
    begin : g_load
      assign load_vals[gi] = seed[gi] & rcr_field_mask(3'(gi));
    end
  endgenerate

  // Reload during reset, held off otherwise
  // reset reload of contents
  assign bank.ld = i_rst;
  assign bank.ld_vals = load_vals;

  // Writes: no state gating, any time after reset
  // unrestricted access
  assign bank.wr_en = i_reg_wr & wr_dec.hit & ~i_rst;
  assign bank.wr_idx = wr_dec.idx;
  assign bank.wr_data = i_reg_wdata & rcr_field_mask(wr_dec.idx);

  // Reads: a miss returns zero from storage
  // reserved address decode
  assign bank.rd_en = i_reg_rd & ~i_rst;
  assign bank.rd_hit = rd_dec.hit;
  assign bank.rd_idx = rd_dec.idx;

  rcr_bank_mem u_mem (
    .i_clk_sys (i_clk_sys),
    .bank (bank)
  );

  // Read valid follows the strobe by one cycle
  logic rvalid_q;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      rvalid_q <= 1'b0;
    else
      rvalid_q <= i_reg_rd;
  end
  assign o_reg_rvalid = rvalid_q;
  assign o_reg_rdata = bank.rd_data;

  // Field outputs are slices of storage flops, no extra logic
  rcr_reg_t r_mode;
  rcr_reg_t r_conf;
  rcr_reg_t r_bkp;
  rcr_reg_t r_ldo1;
  rcr_reg_t r_ldo2;
  rcr_reg_t r_sd;
  rcr_reg_t r_3v3;
  rcr_reg_t r_ldo3;
  assign r_mode = bank.regs[`RCR_IDX_BUCK3_MODE];
  assign r_conf = bank.regs[`RCR_IDX_BUCK3_CONF];
  assign r_bkp = bank.regs[`RCR_IDX_BACKUP];
  assign r_ldo1 = bank.regs[`RCR_IDX_LDO1];
  assign r_ldo2 = bank.regs[`RCR_IDX_LDO2];
  assign r_sd = bank.regs[`RCR_IDX_SD_LDO];
  assign r_3v3 = bank.regs[`RCR_IDX_LDO_3V3];
  assign r_ldo3 = bank.regs[`RCR_IDX_LDO3];

  assign o_buck3_mode_select = r_mode[`RCR_MODE_HI:0];
  assign o_buck3_phase_select = r_conf[`RCR_PHASE_HI:`RCR_PHASE_LO];
  assign o_buck3_frequency_select = r_conf[`RCR_FREQ_HI:`RCR_FREQ_LO];
  assign o_buck3_current_limit_select = r_conf[`RCR_ILIM_BIT];
  assign o_backup_supply_voltage_code = r_bkp[`RCR_BACKUP_HI:0];
  assign o_ldo1_enable = r_ldo1[`RCR_EN_BIT];
  assign o_ldo1_voltage_code = r_ldo1[`RCR_VOLT4_HI:0];
  assign o_ldo2_enable = r_ldo2[`RCR_EN_BIT];
  assign o_ldo2_voltage_code = r_ldo2[`RCR_VOLT4_HI:0];
  assign o_sd_card_ldo_enable = r_sd[`RCR_EN_BIT];
  assign o_sd_card_ldo_voltage_code = r_sd[`RCR_VOLT2_HI:0];
  assign o_ldo_3v3_enable = r_3v3[`RCR_EN_BIT];
  assign o_ldo_3v3_voltage_code = r_3v3[`RCR_VOLT2_HI:0];
  assign o_ldo3_enable = r_ldo3[`RCR_EN_BIT];
  assign o_ldo3_voltage_code = r_ldo3[`RCR_VOLT4_HI:0];

  // Checks on behaviour seen at the ports
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = i_reg_wr && !i_rst;
  assign rd_ok = i_reg_rd && !i_rst && !i_reg_wr;

  mode_write_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    wr_ok && i_reg_addr == `RCR_ADDR_BUCK3_MODE
    |=> o_buck3_mode_select == $past(i_reg_wdata[`RCR_MODE_HI:0]))
    else $error("buck3 mode not updated by write");

  phase_write_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    wr_ok && i_reg_addr == `RCR_ADDR_BUCK3_CONF
    |=> o_buck3_phase_select
      == $past(i_reg_wdata[`RCR_PHASE_HI:`RCR_PHASE_LO]))
    else $error("buck3 phase not updated by write");

  freq_write_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    wr_ok && i_reg_addr == `RCR_ADDR_BUCK3_CONF
    |=> o_buck3_frequency_select
      == $past(i_reg_wdata[`RCR_FREQ_HI:`RCR_FREQ_LO]))
    else $error("buck3 frequency not updated by write");

  ilim_write_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    wr_ok && i_reg_addr == `RCR_ADDR_BUCK3_CONF
    |=> o_buck3_current_limit_select
      == $past(i_reg_wdata[`RCR_ILIM_BIT]))
    else $error("buck3 current limit not updated by write");

  read_answer_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_reg_rd |=> o_reg_rvalid ##1 (!o_reg_rvalid || $past(i_reg_rd)))
    else $error("read not answered one cycle later");

  conf_otp_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    $fell(i_rst)
    |-> r_conf == ($past(i_otp_buck3_conf) & `RCR_MASK_BUCK3_CONF))
    else $error("buck3 setup not loaded from programmed data");

  seq_load_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    $fell(i_rst) |-> o_ldo1_enable == $past(i_seq_ldo1[`RCR_EN_BIT])
      && o_buck3_mode_select
        == $past(i_seq_buck3_mode[`RCR_MODE_HI:0]))
    else $error("start-up values not loaded");

  backup_write_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    wr_ok && i_reg_addr == `RCR_ADDR_BACKUP
    |=> o_backup_supply_voltage_code
      == $past(i_reg_wdata[`RCR_BACKUP_HI:0]))
    else $error("backup voltage not updated by write");

  ldo1_write_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    wr_ok && i_reg_addr == `RCR_ADDR_LDO1
    |=> {o_ldo1_enable, o_ldo1_voltage_code}
      == $past(i_reg_wdata[`RCR_EN_BIT:0]))
    else $error("LDO1 fields not updated by write");

  ldo2_write_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    wr_ok && i_reg_addr == `RCR_ADDR_LDO2
    |=> {o_ldo2_enable, o_ldo2_voltage_code}
      == $past(i_reg_wdata[`RCR_EN_BIT:0]))
    else $error("LDO2 fields not updated by write");

  sd_write_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    wr_ok && i_reg_addr == `RCR_ADDR_SD_LDO
    |=> o_sd_card_ldo_enable == $past(i_reg_wdata[`RCR_EN_BIT])
      && o_sd_card_ldo_voltage_code
        == $past(i_reg_wdata[`RCR_VOLT2_HI:0]))
    else $error("SD card LDO fields not updated by write");

  ldo33_write_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    wr_ok && i_reg_addr == `RCR_ADDR_LDO_3V3
    |=> o_ldo_3v3_enable == $past(i_reg_wdata[`RCR_EN_BIT])
      && o_ldo_3v3_voltage_code
        == $past(i_reg_wdata[`RCR_VOLT2_HI:0]))
    else $error("3.3 V LDO fields not updated by write");

  ldo3_write_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    wr_ok && i_reg_addr == `RCR_ADDR_LDO3
    |=> {o_ldo3_enable, o_ldo3_voltage_code}
      == $past(i_reg_wdata[`RCR_EN_BIT:0]))
    else $error("LDO3 fields not updated by write");

  byte_read_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    rd_ok && i_reg_addr == `RCR_ADDR_LDO1
    |=> o_reg_rdata == {3'h0, $past(o_ldo1_enable),
      $past(o_ldo1_voltage_code)})
    else $error("register byte read back wrong");

  reserved_read_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    rd_ok && !rd_dec.hit |=> o_reg_rdata == `RCR_ZERO_BYTE)
    else $error("reserved address read not zero");

  reserved_write_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    wr_ok && !wr_dec.hit |=> bank.regs == $past(bank.regs))
    else $error("reserved address write changed the bank");

  unused_bits_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    rd_ok && i_reg_addr == `RCR_ADDR_BUCK3_CONF
    |=> (o_reg_rdata & ~`RCR_MASK_BUCK3_CONF) == `RCR_ZERO_BYTE)
    else $error("unused configuration bits not zero");

  seq_rest_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    $fell(i_rst)
    |-> o_backup_supply_voltage_code
        == $past(i_seq_backup[`RCR_BACKUP_HI:0])
      && o_ldo1_voltage_code == $past(i_seq_ldo1[`RCR_VOLT4_HI:0])
      && {o_ldo2_enable, o_ldo2_voltage_code}
        == $past(i_seq_ldo2[`RCR_EN_BIT:0])
      && {o_ldo3_enable, o_ldo3_voltage_code}
        == $past(i_seq_ldo3[`RCR_EN_BIT:0]))
    else $error("start-up supply and LDO values not loaded");

  seq_small_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    $fell(i_rst)
    |-> o_sd_card_ldo_enable == $past(i_seq_sd_ldo[`RCR_EN_BIT])
      && o_sd_card_ldo_voltage_code
        == $past(i_seq_sd_ldo[`RCR_VOLT2_HI:0])
      && o_ldo_3v3_enable == $past(i_seq_ldo_3v3[`RCR_EN_BIT])
      && o_ldo_3v3_voltage_code
        == $past(i_seq_ldo_3v3[`RCR_VOLT2_HI:0]))
    else $error("start-up small LDO values not loaded");

  // Reset cycles must leave the read port idle and zeroed
  reset_quiet_a: assert property (
    @(posedge i_clk_sys)
    i_rst |=> !o_reg_rvalid && o_reg_rdata == `RCR_ZERO_BYTE)
    else $error("read port not quiet after a reset cycle");

  // Reset is taken from the sampled value, so a reload edge is excluded
  field_hold_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !i_reg_wr && !i_rst |=> bank.regs == $past(bank.regs))
    else $error("bank changed without a write");

  byte_mode_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    rd_ok && i_reg_addr == `RCR_ADDR_BUCK3_MODE
    |=> o_reg_rdata == {4'h0, $past(o_buck3_mode_select)})
    else $error("mode register byte read back wrong");

endmodule : rcr_top

//--- sim/rcr_host_model.sv
// Host model: byte reads and writes on the bank's parallel access port.
// Assumes one shared clock and a bench that calls its tasks one at a time.
`timescale 1ns/1ps
module rcr_host_model (
  input wire logic i_clk_sys, // System clock
  output logic [7:0] o_addr, // Register address
  output logic o_wr, // Write strobe
  output logic [7:0] o_wdata, // Write data
  output logic o_rd, // Read strobe
  input wire logic [7:0] i_rdata, // Read data
  input wire logic i_rvalid // Read data valid
);
  // Port idle at time zero
  initial
  begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
  end

  // byte write at any time
  // Released address and data show the inverse, never a stale match
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : write_reg

  // byte read, answer taken once settled after the strobe edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
    output logic ok);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
    o_addr <= ~a;
    // Answer stands for the whole cycle after the taking edge
    #1;
    ok = i_rvalid;
    d = i_rdata;
  endtask : read_reg
endmodule : rcr_host_model

//--- sim/tb_regulator_control_registers.sv
// Self-checking bench for the regulator control bank.
// Assumes the host model drives the access port on rising clock edges.
`timescale 1ns/1ps
`include "rcr_regs.svh"
module tb_regulator_control_registers;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire [7:0] addr;
  wire wr;
  wire [7:0] wdata;
  wire rd;
  wire [7:0] rdata;
  wire rvalid;
  wire [32:0] fld;
  logic [7:0] seed [8] = '{default: 8'h00};
  logic [7:0] m [8];
  logic [7:0] mask [8] = '{8'h0F, 8'h3D, 8'h07, 8'h1F, 8'h1F, 8'h13,
    8'h13, 8'h1F};
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;

  // 125 MHz clock
  initial
  begin
    forever #4 clk = ~clk;
  end

  rcr_host_model host (.i_clk_sys(clk), .o_addr(addr), .o_wr(wr),
    .o_wdata(wdata), .o_rd(rd), .i_rdata(rdata), .i_rvalid(rvalid));

  rcr_top DUT (.i_clk_sys(clk), .i_rst(rst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_otp_buck3_conf(seed[1]), .i_seq_buck3_mode(seed[0]),
    .i_seq_backup(seed[2]), .i_seq_ldo1(seed[3]), .i_seq_ldo2(seed[4]),
    .i_seq_sd_ldo(seed[5]), .i_seq_ldo_3v3(seed[6]), .i_seq_ldo3(seed[7]),
    .o_buck3_mode_select(fld[32:29]), .o_buck3_phase_select(fld[28:27]),
    .o_buck3_frequency_select(fld[26:25]),
    .o_buck3_current_limit_select(fld[24]),
    .o_backup_supply_voltage_code(fld[23:21]),
    .o_ldo1_enable(fld[20]), .o_ldo1_voltage_code(fld[19:16]),
    .o_ldo2_enable(fld[15]), .o_ldo2_voltage_code(fld[14:11]),
    .o_sd_card_ldo_enable(fld[10]), .o_sd_card_ldo_voltage_code(fld[9:8]),
    .o_ldo_3v3_enable(fld[7]), .o_ldo_3v3_voltage_code(fld[6:5]),
    .o_ldo3_enable(fld[4]), .o_ldo3_voltage_code(fld[3:0]));

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // Hang guard, far above the roughly 600 cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("FAIL at %0t: run did not finish", $time);
      complete_run();
    end
  end

  // Reset held six cycles; seeds carry stray bits to prove masking
  task automatic apply_reset(input logic [7:0] pat);
    logic [7:0] sv;
    @(posedge clk);
    rst <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      sv = pat ^ (8'h11 * i[7:0]);
      seed[i] <= sv;
      m[i] = sv & mask[i];
    end
    // Strobes while reset is held must be ignored
    host.write_reg(`RCR_ADDR_LDO1, 8'hFF);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask : apply_reset

  // Read one byte and compare valid and data
  task automatic chk_read(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host.read_reg(a, d, ok);
    check_count++;
    if (ok !== 1'b1 || d !== e)
    begin
      error_cnt++;
      $display("FAIL at %0t: read %h gave %h/%b, expected %h", $time, a, d,
        ok, e);
    end
  endtask : chk_read

  // Field outputs against the mirror, after the edge's updates land
  task automatic chk_fields();
    logic [32:0] e;
    #1;
    e = {m[0][3:0], m[1][5:4], m[1][3:2], m[1][0], m[2][2:0], m[3][4:0],
      m[4][4:0], m[5][4], m[5][1:0], m[6][4], m[6][1:0], m[7][4:0]};
    check_count++;
    if (fld !== e)
    begin
      error_cnt++;
      $display("FAIL at %0t: fields %h, expected %h", $time, fld, e);
    end
  endtask : chk_fields

  // Every register read back and every field output compared
  task automatic check_all();
    for (int i = 0; i < 8; i++)
    begin
      chk_read(`RCR_ADDR_BUCK3_MODE + i[7:0], m[i]);
    end
    chk_fields();
  endtask : check_all

  initial
  begin
    apply_reset(8'hFF);
    check_all();
    $display("Test reset load done");
    // Sweep every code of every field, both nibbles alike
    for (int v = 0; v < 16; v++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        host.write_reg(`RCR_ADDR_BUCK3_MODE + i[7:0], 8'h11 * v[7:0]);
        m[i] = (8'h11 * v[7:0]) & mask[i];
      end
      check_all();
    end
    $display("Test code sweep done");
    // Reserved places around the bank take nothing and read zero
    host.write_reg(8'h1F, 8'hFF);
    host.write_reg(8'h28, 8'hFF);
    host.write_reg(8'hFF, 8'hFF);
    chk_read(8'h1F, 8'h00);
    chk_read(8'h28, 8'h00);
    chk_read(8'h00, 8'h00);
    check_all();
    $display("Test reserved addresses done");
    // Second reset mid-run reloads from fresh seeds
    apply_reset(8'hA5);
    check_all();
    $display("Test second reset done");
    complete_run();
  end
endmodule : tb_regulator_control_registers
